// file: pkg/led_link_pkg.sv
// Shared constants for the one-wire grayscale link and its two ends
package led_link_pkg;
    localparam int          PACKET_BITS      = 32;
    localparam int          LEVEL_BITS       = 24;
    localparam int          CHAN_BITS        = 8;
    localparam int          CMD_MSB          = 31;
    localparam int          CMD_LSB          = 24;
    localparam int          FIRST_LSB        = 16;
    localparam int          SECOND_LSB       = 8;
    localparam int          THIRD_LSB        = 0;
    localparam logic [7:0]  PACKET_WRITE_COMMAND = 8'h3a;
    localparam logic [23:0] LEVEL_RESET      = 24'h000000;
    // Clock and link timing
    localparam int          CLK_MHZ          = 200;
    localparam int          BIT_PERIOD_NS    = 2000;
    localparam int          BIT_PERIOD_CYC   = BIT_PERIOD_NS * CLK_MHZ / 1000;
    localparam int          ONE_HIGH_CYC     = BIT_PERIOD_CYC / 4;
    // Bit slot decode: an extra edge before half the period means a one
    localparam int          HALF_PERIOD_CYC  = BIT_PERIOD_CYC / 2;
    // End-of-packet hold is 3.5 periods, latch hold 8 periods of idle low
    localparam int          END_HOLD_NS      = 7000;
    localparam int          END_HOLD_CYC     = END_HOLD_NS * CLK_MHZ / 1000;
    localparam int          LATCH_HOLD_NS    = 16000;
    localparam int          LATCH_HOLD_CYC   = LATCH_HOLD_NS * CLK_MHZ / 1000;
    // Internal pwm reference tick, 6 MHz nominal from 200 MHz
    localparam int          PWM_TICK_DIV     = 33;
    localparam int          CNT_W            = 16;
endpackage

// file: pkg/led_link_if.sv
// One-wire link between the controller end and a chain of drivers
`timescale 1ns/100ps
`default_nettype none
interface led_link_if;
    logic serial_input_pin;   // Controller to first driver
    logic serial_output_pin;  // Forwarded stream out of the driver
    modport controller (output serial_input_pin, input serial_output_pin);
    modport driver     (input serial_input_pin, output serial_output_pin);
endinterface
`default_nettype wire

// file: hdl/led_driver_end.sv
// Driver end: one-wire decoder, shift register, level latch and PWM
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - 32-bit shift register, separate 24-bit level latch
// - Latch copies low 24 bits on command 3Ah
// - Wrong command leaves latch unchanged
// - Bits 0-7 drive third channel
// - Bits 8-15 drive second channel
// - Bits 16-23 drive first channel
// - Sender puts 00111010b in top byte
// - PWM tick from own internal divider
// - Drivers chain by forwarding the serial stream
// - Controller sends one 32-bit packet per driver
// - Output on while counter at or below level
// - Long low hold latches levels, restarts PWM
// - Packets go most significant bit first
// - End hold freezes register, starts forwarding
module led_driver_end
    import led_link_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rstn_i,
    led_link_if.driver                  link,
    output logic                        first_sink_output_o,
    output logic                        second_sink_output_o,
    output logic                        third_sink_output_o,
    output logic [led_link_pkg::LEVEL_BITS-1:0] level_o
);
    import led_link_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE    = 3'b001,
        ST_SLOT    = 3'b010,
        ST_FORWARD = 3'b100
    } rx_state_e;

    rx_state_e               state_reg;
    logic                    sync1_reg;
    logic                    sync2_reg;
    logic                    prev_reg;
    logic [CNT_W-1:0]        low_cnt_reg;
    logic [CNT_W-1:0]        slot_cnt_reg;
    logic                    extra_edge_reg;
    logic [PACKET_BITS-1:0]  shift_reg;
    logic [LEVEL_BITS-1:0]   level_reg;
    logic [5:0]              tick_cnt_reg;
    logic [CHAN_BITS-1:0]    pwm_cnt_reg;
    logic                    fwd_reg;
    logic                    rise;
    logic                    latch_pulse;
    logic                    tick;

    // ------------------------------------------------------------
    // Input synchroniser and edge detect
    // ------------------------------------------------------------
    // Pin is asynchronous to our clock
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else
        begin
            sync1_reg <= link.serial_input_pin;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;

    // Low-time counter for end and latch holds, saturating
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            low_cnt_reg <= '0;
        else if (sync2_reg)
            low_cnt_reg <= '0;
        else if (low_cnt_reg != {CNT_W{1'b1}})
            low_cnt_reg <= low_cnt_reg + 1'b1;
    end

    // At most one pulse per idle stretch
    assign latch_pulse = !sync2_reg
                         && low_cnt_reg == CNT_W'(LATCH_HOLD_CYC);

    // ------------------------------------------------------------
    // Bit decoder and forwarding state
    // ------------------------------------------------------------
    // Fixed bit period stands in for the measured one
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg       <= ST_IDLE;
            slot_cnt_reg    <= '0;
            extra_edge_reg  <= 1'b0;
            shift_reg       <= '0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (rise)
                    begin
                        state_reg      <= ST_SLOT;
                        slot_cnt_reg   <= '0;
                        extra_edge_reg <= 1'b0;
                    end
                end
                ST_SLOT:
                begin
                    slot_cnt_reg <= slot_cnt_reg + 1'b1;
                    if (rise && slot_cnt_reg < CNT_W'(HALF_PERIOD_CYC))
                        extra_edge_reg <= 1'b1;
                    else if (rise)
                    begin
                        // Late rise closes the slot; idle time adds no bits
                        shift_reg <= {shift_reg[PACKET_BITS-2:0],
                                      extra_edge_reg};
                        slot_cnt_reg   <= '0;
                        extra_edge_reg <= 1'b0;
                    end
                    if (!sync2_reg
                        && low_cnt_reg == CNT_W'(END_HOLD_CYC))
                    begin
                        state_reg <= ST_FORWARD;
                    end
                end
                ST_FORWARD:
                begin
                    // Register frozen; stream passes on until latch
                    if (latch_pulse)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Forward the buffered input once our packet is done
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            fwd_reg <= 1'b0;
        else
            fwd_reg <= (state_reg == ST_FORWARD) & sync2_reg;
    end

    assign link.serial_output_pin = fwd_reg;

    // ------------------------------------------------------------
    // Level latch
    // ------------------------------------------------------------
    // Only a valid command byte updates the levels
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            level_reg <= LEVEL_RESET;
        else if (latch_pulse
                 && shift_reg[CMD_MSB:CMD_LSB] == PACKET_WRITE_COMMAND)
            level_reg <= shift_reg[LEVEL_BITS-1:0];
        // Else keep old levels
    end

    assign level_o = level_reg;

    // ------------------------------------------------------------
    // PWM from internal tick
    // ------------------------------------------------------------
    // Divider replaces an external grayscale clock
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            tick_cnt_reg <= '0;
        else if (tick || latch_pulse)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    assign tick = (tick_cnt_reg == 6'(PWM_TICK_DIV - 1));

    // Counter restarts on latch so new levels start a fresh cycle
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pwm_cnt_reg <= '0;
        else if (latch_pulse)
            pwm_cnt_reg <= '0;
        else if (tick)
            pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
    end

    // Level zero still lights one step, as counter includes equality
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            first_sink_output_o  <= 1'b0;
            second_sink_output_o <= 1'b0;
            third_sink_output_o  <= 1'b0;
        end
        else
        begin
            first_sink_output_o  <= pwm_cnt_reg <=
                level_reg[FIRST_LSB +: CHAN_BITS];
            second_sink_output_o <= pwm_cnt_reg <=
                level_reg[SECOND_LSB +: CHAN_BITS];
            third_sink_output_o  <= pwm_cnt_reg <=
                level_reg[THIRD_LSB +: CHAN_BITS];
        end
    end
endmodule
`default_nettype wire

// file: hdl/led_controller_end.sv
// Controller end: serialises packets onto the one-wire link
`timescale 1ns/100ps
`default_nettype none
module led_controller_end
    import led_link_pkg::*;
(
    input  wire logic                       clock_i,
    input  wire logic                       rstn_i,
    led_link_if.controller                  link,
    input  wire logic                       send_i,
    input  wire logic                       last_i,
    input  wire logic [led_link_pkg::CHAN_BITS-1:0] first_level_i,
    input  wire logic [led_link_pkg::CHAN_BITS-1:0] second_level_i,
    input  wire logic [led_link_pkg::CHAN_BITS-1:0] third_level_i,
    output logic                            ready_o
);
    import led_link_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_BITS = 3'b010,
        ST_HOLD = 3'b100
    } tx_state_e;

    tx_state_e              state_reg;
    logic [PACKET_BITS-1:0] pkt_reg;
    logic [5:0]             bit_cnt_reg;
    logic [CNT_W-1:0]       cyc_reg;
    logic [CNT_W-1:0]       hold_reg;
    logic                   pin_reg;

    // ------------------------------------------------------------
    // Packet serialiser
    // ------------------------------------------------------------
    // Rise at slot start; a one adds a second rise at a quarter
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg   <= ST_IDLE;
            pkt_reg     <= '0;
            bit_cnt_reg <= '0;
            cyc_reg     <= '0;
            hold_reg    <= '0;
            pin_reg     <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    pin_reg <= 1'b0;
                    if (send_i)
                    begin
                        pkt_reg <= {PACKET_WRITE_COMMAND, first_level_i,
                                    second_level_i, third_level_i};
                        // Low time starts after the closing rise, plus margin
                        hold_reg <= last_i
                            ? CNT_W'(LATCH_HOLD_CYC + ONE_HIGH_CYC / 2 + 8)
                            : CNT_W'(END_HOLD_CYC + ONE_HIGH_CYC / 2 + 8);
                        bit_cnt_reg <= '0;
                        cyc_reg     <= '0;
                        state_reg   <= ST_BITS;
                    end
                end
                ST_BITS:
                begin
                    cyc_reg <= cyc_reg + 1'b1;
                    if (cyc_reg == '0)
                        pin_reg <= 1'b1;
                    else if (cyc_reg == CNT_W'(ONE_HIGH_CYC / 2))
                        pin_reg <= 1'b0;
                    else if (cyc_reg == CNT_W'(ONE_HIGH_CYC))
                        pin_reg <= pkt_reg[PACKET_BITS-1];
                    else if (cyc_reg == CNT_W'(ONE_HIGH_CYC * 3 / 2))
                        pin_reg <= 1'b0;
                    if (cyc_reg == CNT_W'(BIT_PERIOD_CYC - 1))
                    begin
                        cyc_reg <= '0;
                        pkt_reg <= {pkt_reg[PACKET_BITS-2:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        if (bit_cnt_reg == 6'(PACKET_BITS - 1))
                        begin
                            cyc_reg   <= '0;
                            state_reg <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD:
                begin
                    // Close the last slot with a rise, then hold low
                    cyc_reg <= cyc_reg + 1'b1;
                    pin_reg <= (cyc_reg < CNT_W'(ONE_HIGH_CYC / 2));
                    if (cyc_reg == hold_reg)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign link.serial_input_pin = pin_reg;
    assign ready_o = (state_reg == ST_IDLE);
endmodule
`default_nettype wire

// file: sim/led_link_assertions.sv
// Concurrent checks on the controller to first driver link
`timescale 1ns/100ps
`default_nettype none
module led_link_assertions
    import led_link_pkg::*;
(
    input  wire logic                                clock_i,
    input  wire logic                                rstn_i,
    input  wire logic                                serial_input_pin,
    input  wire logic                                serial_output_pin,
    input  wire logic                                send_i,
    input  wire logic                                ready_o,
    input  wire logic                                first_sink_output_o,
    input  wire logic [led_link_pkg::LEVEL_BITS-1:0] level_o
);
    logic [15:0] high_reg;
    logic [15:0] low_reg;
    logic [4:0]  hist_reg;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // ----------------------------------------
    // Wire run lengths
    // ----------------------------------------
    // Low run starts saturated: an idle line counts as a long hold
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            high_reg <= 16'h0;
            low_reg  <= 16'hffff;
            hist_reg <= 5'h0;
        end
        else
        begin
            high_reg <= serial_input_pin ? high_reg + 16'h1 : 16'h0;
            low_reg  <= serial_input_pin ? 16'h0 :
                        (&low_reg ? low_reg : low_reg + 16'h1);
            hist_reg <= {hist_reg[3:0], serial_input_pin};
        end
    end

    high_run_a: assert property ($fell(serial_input_pin) |-> high_reg == 16'h32)
        else $error("high pulse length wrong");
    low_run_a: assert property ($rose(serial_input_pin) |-> low_reg == 16'h32 ||
        low_reg == 16'hfa || low_reg == 16'h15e || low_reg >= 16'h578)
        else $error("low gap length wrong");
    line_idle_a: assert property (ready_o |-> !serial_input_pin)
        else $error("line not idle low");
    level_hold_a: assert property ($changed(level_o) |-> !serial_input_pin)
        else $error("level changed during traffic");
    reset_level_a: assert property ($rose(rstn_i) |-> level_o == 24'h0)
        else $error("level not cleared");
    ready_drop_a: assert property (send_i && ready_o |=> !ready_o)
        else $error("ready stayed high");
    ready_low_a: assert property ($fell(ready_o) |-> !ready_o [*8])
        else $error("ready rose early");
    slot_start_a: assert property ($fell(ready_o) |-> ##[0:2] serial_input_pin)
        else $error("packet did not start");
    forward_echo_a: assert property ($rose(serial_output_pin) |-> |hist_reg)
        else $error("forwarded rise without input");
    full_on_a: assert property (level_o[23:16] == 8'hff [*3]
        |-> first_sink_output_o)
        else $error("full level not on");
endmodule
`default_nettype wire

// file: sim/rgb_grayscale_latch_pwm_tb.sv
// Bench: controller, two chained drivers, one hand-fed driver
`timescale 1ns/100ps
`default_nettype none
module rgb_grayscale_latch_pwm_tb;
    import led_link_pkg::*;
    typedef struct packed {
        logic [23:0] near_lv;
        logic [23:0] far_lv;
    } row_s;
    // First packet stays in the near driver, second goes on
    localparam row_s ROWS [2] = '{'{24'hff0080, 24'h017ffe},
                                  '{24'ha55a01, 24'h00ff00}};
    logic        clock_i;
    logic        rstn_i;
    logic        send_i;
    logic        last_i;
    logic [23:0] lv;
    logic        raw_pin;
    logic        ready_o;
    logic        sink_1;
    logic        chan_1;
    logic        chan_2;
    logic        chan_3;
    logic [23:0] level_1;
    logic [23:0] level_2;
    logic [23:0] level_3;
    int          miscompares = 0;
    int          compares = 0;
    int          cycles = 0;

    led_link_if link_a();
    led_link_if link_b();
    led_link_if link_c();
    assign link_b.serial_input_pin = link_a.serial_output_pin;
    assign link_c.serial_input_pin = raw_pin;

    led_controller_end i_led_controller_end (.clock_i(clock_i),
        .rstn_i(rstn_i), .link(link_a), .send_i(send_i), .last_i(last_i),
        .first_level_i(lv[23:16]), .second_level_i(lv[15:8]),
        .third_level_i(lv[7:0]), .ready_o(ready_o));
    led_driver_end i_led_driver_end (.clock_i(clock_i), .rstn_i(rstn_i),
        .link(link_a), .first_sink_output_o(sink_1),
        .second_sink_output_o(), .third_sink_output_o(), .level_o(level_1));
    led_driver_end i_led_driver_end_2 (.clock_i(clock_i), .rstn_i(rstn_i),
        .link(link_b), .first_sink_output_o(), .second_sink_output_o(),
        .third_sink_output_o(), .level_o(level_2));
    led_driver_end i_led_driver_end_3 (.clock_i(clock_i), .rstn_i(rstn_i),
        .link(link_c), .first_sink_output_o(chan_1),
        .second_sink_output_o(chan_2), .third_sink_output_o(chan_3),
        .level_o(level_3));
    led_link_assertions i_led_link_assertions (.clock_i(clock_i),
        .rstn_i(rstn_i), .serial_input_pin(link_a.serial_input_pin),
        .serial_output_pin(link_a.serial_output_pin), .send_i(send_i),
        .ready_o(ready_o), .first_sink_output_o(sink_1), .level_o(level_1));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Longest branch needs about 61000 cycles
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic cmp_lv(input logic [23:0] act, input logic [23:0] exp);
        compares++;
        if (act !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: level %h want %h", $time, act, exp);
        end
    endtask

    task automatic cmp_bit(input logic act, input logic exp);
        compares++;
        if (act !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: bit %b want %b", $time, act, exp);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 20000)
        begin
            @(negedge clock_i);
            n++;
        end
        // A stuck controller counts against the run
        if (n == 20000)
        begin
            miscompares++;
            $display("unexpected at %0t: controller never ready", $time);
        end
    endtask

    task automatic send(input logic [23:0] v, input logic last);
        wait_ready();
        send_i = 1'b1;
        last_i = last;
        lv = v;
        @(negedge clock_i);
        send_i = 1'b0;
    endtask

    task automatic raw_bits(input logic v, input int n);
        raw_pin = v;
        repeat (n) @(negedge clock_i);
    endtask

    // Hand-made packet, same slot shape as the controller
    task automatic raw_send(input logic [31:0] p);
        for (int i = 31; i >= 0; i--)
        begin
            raw_bits(1'b1, 50);
            raw_bits(1'b0, 50);
            raw_bits(p[i], 50);
            raw_bits(1'b0, 250);
        end
        raw_bits(1'b1, 50);
        raw_bits(1'b0, 3220);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rstn_i = 1'b0;
        send_i = 1'b0;
        last_i = 1'b0;
        lv = 24'h0;
        raw_pin = 1'b0;
        repeat (5) @(negedge clock_i);
        cmp_lv(level_1, LEVEL_RESET);
        cmp_bit(ready_o, 1'b1);
        rstn_i = 1'b1;
        fork
            foreach (ROWS[r])
            begin
                send(ROWS[r].near_lv, 1'b0);
                send(ROWS[r].far_lv, 1'b1);
                wait_ready();
                repeat (20) @(negedge clock_i);
                cmp_lv(level_1, ROWS[r].near_lv);
                cmp_lv(level_2, ROWS[r].far_lv);
                cmp_bit(link_a.serial_input_pin, 1'b0);
                if (ROWS[r].near_lv[23:16] == 8'hff)
                    cmp_bit(sink_1, 1'b1);
            end
            begin
                raw_send({PACKET_WRITE_COMMAND, 24'h123456});
                cmp_lv(level_3, 24'h123456);
                // About 67 ticks after the latch: past 34h, short of 56h
                raw_bits(1'b0, 2200);
                cmp_bit(chan_1, 1'b0);
                cmp_bit(chan_2, 1'b0);
                cmp_bit(chan_3, 1'b1);
                raw_send({8'h3b, 24'habcdef});
                cmp_lv(level_3, 24'h123456);
            end
        join
        // Second reset mid-run clears the latch and outputs
        rstn_i = 1'b0;
        @(negedge clock_i);
        cmp_lv(level_1, LEVEL_RESET);
        cmp_bit(sink_1, 1'b0);
        rstn_i = 1'b1;
        repeat (2) @(negedge clock_i);
        cmp_bit(ready_o, 1'b1);
        cmp_lv(level_2, LEVEL_RESET);
        end_of_test();
    end
endmodule
`default_nettype wire
